// file: bench/ehci_cap_properties.sv
// pin-level assertions for the capability register bank
`timescale 1ns/10ps
`default_nettype none
module ehci_cap_properties
  import ehci_cap_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire host_pins_t HOST_PINS_I,
  input wire logic [31:0] DATA_I,
  input wire logic [31:0] DATA_O,
  input wire logic DATA_OE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  wire logic rd = !HOST_PINS_I.chip_sel_n && !HOST_PINS_I.read_n;
  wire logic [16:0] a = HOST_PINS_I.addr;
  wire logic b = HOST_PINS_I.bus_16bit;
  // ==========================================================================
  // read held four edges, then data
  // ==========================================================================
  sequence held(logic [16:0] x, logic m);
    (rd && a == x && b == m)[*4];
  endsequence
  property word(logic [16:0] x, logic m, logic [31:0] v);
    held(x, m) |=> DATA_OE_O && DATA_O == v;
  endproperty
  idle_zero_a: assert property (!DATA_OE_O |-> DATA_O == 32'h0)
    else $error("data while idle");
  drive_inside_a: assert property ((rd && a < 17'h10)[*4] |=> DATA_OE_O)
    else $error("no drive");
  quiet_outside_a: assert property ((!rd || a >= 17'h10)[*4] |=> !DATA_OE_O)
    else $error("stray drive");
  length_version_a: assert property (word(17'h0, 1'b0, 32'h01000020))
    else $error("bad dword 0");
  struct_params_a: assert property (
    word(17'h2, 1'b0, 32'h00000011))
    else $error("bad dword 4");
  cap_params_a: assert property (
    word(17'h4, 1'b0, 32'h00000086))
    else $error("bad dword 8");
  version_half_a: assert property (word(17'h1, 1'b1, 32'h00000100))
    else $error("bad high half");
  spare_zero_a: assert property (word(17'h6, 1'b0, 32'h0))
    else $error("spare word not zero");
endmodule : ehci_cap_properties
bind ehci_capability_registers ehci_cap_properties u_props (.SYS_CLK_I(SYS_CLK_I),
  .NRST_I(NRST_I), .HOST_PINS_I(HOST_PINS_I), .DATA_I(DATA_I), .DATA_O(DATA_O),
  .DATA_OE_O(DATA_OE_O));
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the capability register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ehci_cap_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  host_pins_t pins = HOST_PINS_IDLE;
  logic [31:0] din = 32'h0;
  wire logic [31:0] dout;
  wire logic oe;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  ehci_capability_registers DUT (.SYS_CLK_I(clk), .NRST_I(nrst), .HOST_PINS_I(pins),
    .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe));
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // strobe held four edges, then idle again
  task automatic rd(input logic [16:0] a, input logic b, input logic e, input logic [31:0] v);
    @(negedge clk);
    pins = '{chip_sel_n: 1'b0, read_n: 1'b0, write_n: 1'b1, bus_16bit: b, addr: a};
    repeat (4) @(negedge clk);
    chk({oe, dout}, {e, v});
    pins = HOST_PINS_IDLE;
    repeat (4) @(negedge clk);
    chk({oe, dout}, 33'h0);
  endtask : rd
  task automatic t_regs();
    rd(17'h0, 1'b0, 1'b1, 32'h01000020);
    rd(17'h2, 1'b0, 1'b1, 32'h00000011);
    rd(17'h5, 1'b0, 1'b1, 32'h00000086);
    rd(17'he, 1'b0, 1'b1, 32'h0);
    rd(17'h10, 1'b0, 1'b0, 32'h0);
  endtask : t_regs
  task automatic t_half();
    rd(17'h0, 1'b1, 1'b1, 32'h0020);
    rd(17'h1, 1'b1, 1'b1, 32'h0100);
    rd(17'h3, 1'b1, 1'b1, 32'h0);
    rd(17'h4, 1'b1, 1'b1, 32'h0086);
  endtask : t_half
  task automatic t_write();
    @(negedge clk);
    // reserved fields written as zero, every defined field inverted except port count, written all ones
    din = 32'h00f1ff8f;
    pins = '{chip_sel_n: 1'b0, read_n: 1'b1, write_n: 1'b0, bus_16bit: 1'b0, addr: 17'h2};
    repeat (6) @(negedge clk);
    chk({oe, dout}, 33'h0);
    pins = HOST_PINS_IDLE;
    rd(17'h2, 1'b0, 1'b1, 32'h00000011);
  endtask : t_write
  task automatic t_rst();
    @(negedge clk);
    pins = '{chip_sel_n: 1'b0, read_n: 1'b0, write_n: 1'b1, bus_16bit: 1'b0, addr: 17'h4};
    repeat (5) @(negedge clk);
    nrst = 1'b0;
    pins = HOST_PINS_IDLE;
    #1;
    chk({oe, dout}, 33'h0);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rd(17'h4, 1'b0, 1'b1, 32'h00000086);
  endtask : t_rst
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_half();
    t_write();
    t_rst();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

// file: hw/ehci_cap_pkg.sv
// constants and types for the host controller capability register bank
package ehci_cap_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  // ==========================================================================
  localparam logic [17:0] CAP_LENGTH_OFS = 18'h00000;
  localparam logic [17:0] IFACE_VERSION_OFS = 18'h00002;
  localparam logic [17:0] STRUCT_PARAMS_OFS = 18'h00004;
  localparam logic [17:0] CAP_PARAMS_OFS = 18'h00008;

  // ==========================================================================
  // fixed register values
  // ==========================================================================
  localparam logic [7:0] CAP_LENGTH_VAL = 8'h20;
  localparam logic [15:0] IFACE_VERSION_VAL = 16'h0100;
  localparam logic [3:0] PORT_COUNT_VAL = 4'h1;
  localparam logic PORT_POWER_VAL = 1'b1;
  localparam logic PORT_ROUTING_VAL = 1'b0;
  localparam logic PORT_INDICATOR_VAL = 1'b0;
  localparam logic [3:0] DEBUG_PORT_VAL = 4'h0;
  localparam logic [3:0] COMPANION_COUNT_VAL = 4'h0;
  localparam logic [3:0] PORTS_PER_COMP_VAL = 4'h0;
  localparam logic [7:0] EXT_CAP_PTR_VAL = 8'h00;
  localparam logic [3:0] ISO_THRESHOLD_VAL = 4'h8;
  localparam logic ASYNC_PARK_VAL = 1'b1;
  localparam logic PROG_FRAME_LIST_VAL = 1'b1;

  // ==========================================================================
  // field layouts
  // ==========================================================================
  typedef struct packed {
    logic [7:0] rsvd_31_24;
    logic [3:0] debug_port_number;
    logic [2:0] rsvd_19_17;
    logic port_indicator;
    logic [3:0] companion_controller_count;
    logic [3:0] ports_per_companion;
    logic port_routing_rules;
    logic [1:0] rsvd_6_5;
    logic port_power_control_present;
    logic [3:0] downstream_port_count;
  } structural_parameters_t;

  typedef struct packed {
    logic [15:0] rsvd_31_16;
    logic [7:0] extended_capability_pointer;
    logic [3:0] isochronous_schedule_threshold;
    logic rsvd_3;
    logic async_park_capable;
    logic programmable_frame_list_flag;
    logic rsvd_0;
  } capability_parameters_t;

  // processor interface pins as sampled
  typedef struct packed {
    logic chip_sel_n;
    logic read_n;
    logic write_n;
    logic bus_16bit;
    logic [17:1] addr;
  } host_pins_t;

  localparam host_pins_t HOST_PINS_IDLE = '{
    chip_sel_n: 1'b1, read_n: 1'b1, write_n: 1'b1, bus_16bit: 1'b0, addr: 17'h00000};

endpackage : ehci_cap_pkg

// file: hw/ehci_capability_registers.sv
// read-only host controller capability register bank behind the processor pins
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - capability length reads 20h, bits 7..0
// - interface version reads 0100h, bits 15..0
// - downstream port count field reads one
// - port power control bit reads one
// - debug port number field reads zero
// - port indicator bit reads zero
// - companion counts both read zero
// - port routing rules bit reads zero
// - reserved bits read zero; software writes zero
// - extended capability pointer reads zero
// - isochronous threshold reads binary 1000
// - asynchronous park capability bit reads one
// - programmable frame list flag reads one
module ehci_capability_registers
  import ehci_cap_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire host_pins_t HOST_PINS_I,
  input wire logic [31:0] DATA_I,
  output logic [31:0] DATA_O,
  output logic DATA_OE_O
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    host_pins_t sync1;
    host_pins_t sync2;
    logic [31:0] rdata;
    logic rdata_oe;
  } state_t;

  localparam state_t STATE_RESET = '{
    sync1: HOST_PINS_IDLE, sync2: HOST_PINS_IDLE, rdata: 32'h00000000, rdata_oe: 1'b0};

  state_t state_reg;
  state_t state_next;

  // ==========================================================================
  // fixed register contents
  // ==========================================================================
  structural_parameters_t struct_params;
  capability_parameters_t cap_params;

  always_comb
  begin
    struct_params = '0;
    struct_params.downstream_port_count = PORT_COUNT_VAL;
    struct_params.port_power_control_present = PORT_POWER_VAL;
    struct_params.debug_port_number = DEBUG_PORT_VAL;
    struct_params.port_indicator = PORT_INDICATOR_VAL;
    struct_params.companion_controller_count = COMPANION_COUNT_VAL;
    struct_params.ports_per_companion = PORTS_PER_COMP_VAL;
    struct_params.port_routing_rules = PORT_ROUTING_VAL;
    cap_params = '0;
    cap_params.extended_capability_pointer = EXT_CAP_PTR_VAL;
    cap_params.isochronous_schedule_threshold = ISO_THRESHOLD_VAL;
    cap_params.async_park_capable = ASYNC_PARK_VAL;
    cap_params.programmable_frame_list_flag = PROG_FRAME_LIST_VAL;
  end

  // ==========================================================================
  // read decode
  // ==========================================================================
  logic read_active;
  logic cap_hit;
  logic [31:0] dword;

  always_comb
  begin
    read_active = ~state_reg.sync2.chip_sel_n & ~state_reg.sync2.read_n;
    cap_hit = ({state_reg.sync2.addr, 1'b0} < {10'h000, CAP_LENGTH_VAL});
    unique case ({state_reg.sync2.addr[17:2], 2'b00})
      CAP_LENGTH_OFS:
        dword = {IFACE_VERSION_VAL, 8'h00, CAP_LENGTH_VAL};
      STRUCT_PARAMS_OFS:
        dword = struct_params;
      CAP_PARAMS_OFS:
        dword = cap_params;
      default:
        dword = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    state_next = state_reg;
    state_next.sync1 = HOST_PINS_I;
    state_next.sync2 = state_reg.sync1;
    // writes (DATA_I) never reach storage; contents are constants
    state_next.rdata_oe = read_active & cap_hit;
    if (!(read_active & cap_hit))
    begin
      state_next.rdata = 32'h00000000;
    end
    else if (state_reg.sync2.bus_16bit)
    begin
      // narrow bus: A1 picks the half, low lanes carry it
      if (state_reg.sync2.addr[1])
      begin
        state_next.rdata = {16'h0000, dword[31:16]};
      end
      else
      begin
        state_next.rdata = {16'h0000, dword[15:0]};
      end
    end
    else
    begin
      state_next.rdata = dword;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign DATA_O = state_reg.rdata;
  assign DATA_OE_O = state_reg.rdata_oe;

endmodule : ehci_capability_registers

`default_nettype wire
